// [dv/digipot_assertions.sv]
`timescale 1ns/1ps
// ****************************************
// port relations of the serial control
// ****************************************
module digipot_assertions (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial link pins
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    input wire wp_n_pin,
    // open-drain outputs
    input wire sdo_out,
    input wire sdo_oe,
    input wire ready_out,
    input wire ready_oe,
    // channel outputs and power state
    input wire [7:0] wiper0,
    input wire [7:0] wiper1,
    input wire buffer_enable0,
    input wire buffer_enable1,
    input wire standby,
    input wire active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // four cycles covers the pin synchroniser
    chk_sdo_released: assert property (cs_n_pin[*4] |-> !sdo_oe)
        else $error("sdo pulled while deselected");
    chk_pins_drain: assert property (sdo_out == 1'b0 && ready_out == 1'b0)
        else $error("open-drain value not low");
    chk_standby_excl: assert property (!(standby && active))
        else $error("standby and active together");
    chk_active_sel: assert property ((!cs_n_pin)[*4] |-> active)
        else $error("selected but not active");
    chk_standby_idle: assert property ((cs_n_pin && !ready_oe)[*4] |-> standby)
        else $error("idle and deselected but no standby");
    chk_busy_len: assert property ($rose(ready_oe) |-> ready_oe[*8] ##1 ready_oe[*8] ##1 !ready_oe)
        else $error("busy not sixteen cycles");
    chk_busy_cause: assert property ($rose(ready_oe) |-> cs_n_pin && $past(cs_n_pin, 2))
        else $error("busy without a finished frame");
    chk_wiper_quiet: assert property ($changed({wiper1, wiper0, buffer_enable1, buffer_enable0})
        |-> cs_n_pin && $past(cs_n_pin))
        else $error("wiper moved inside a frame");
endmodule // digipot_assertions

// [dv/host_model.sv]
`timescale 1ns/1ps
// ****************************************
// serial bus master
// ****************************************
module host_model (
    // clock
    input wire clk,
    // link pins
    output reg cs_n_pin,
    output reg sclk_pin,
    output reg sdi_pin,
    input wire sdo_w
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    // half period of 20 cycles gives the 160 ns link clock; it stands low between frames
    task xfer(input [23:0] w, input integer n, output [23:0] rx);
        integer b;
        rx = 24'h000000;
        @(posedge clk);
        cs_n_pin <= 1'b0;
        sdi_pin <= w[23];
        for (b = 0; b < n; b = b + 1) begin
            repeat (20) @(posedge clk);
            sclk_pin <= 1'b1;
            rx = {rx[22:0], sdo_w};
            repeat (20) @(posedge clk);
            sclk_pin <= 1'b0;
            // next data bit changes with the clock fall, half a period before its rise
            if (b < 23) begin
                sdi_pin <= w[22 - b];
            end
        end
        repeat (20) @(posedge clk);
        cs_n_pin <= 1'b1;
        // a released data line must not keep its last bit
        sdi_pin <= ~sdi_pin;
        repeat (8) @(posedge clk);
    endtask
endmodule // host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "digipot_regs.vh"
// ****************************************
// scenarios
// ****************************************
module testbench;
    localparam [8:0] nv = `DP_NV_RESET;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg wp_n_pin = 1'b1;
    wire cs_n_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe, ready_out, ready_oe;
    wire buffer_enable0, buffer_enable1, standby, active;
    wire [7:0] wiper0, wiper1;
    wire sdo_w = !sdo_oe;
    reg [23:0] rx;
    integer error_cnt = 0, n_checks = 0, cycles = 0, i;
    always #2 clk = ~clk;
    dual_digipot_serial_control u_dual_digipot_serial_control (.clk(clk), .arst_n(arst_n),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .wp_n_pin(wp_n_pin),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ready_out(ready_out), .ready_oe(ready_oe),
        .wiper0(wiper0), .wiper1(wiper1), .buffer_enable0(buffer_enable0),
        .buffer_enable1(buffer_enable1), .standby(standby), .active(active));
    host_model u_host_model (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
        .sdo_w(sdo_w));
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check(input [95:0] what, input [23:0] exp, input [23:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s exp %h got %h", what, exp, got);
        end
    endtask
    function [23:0] wd(input [3:0] c, input [1:0] s, input [1:0] ch, input b, input [7:0] t);
        wd = {c, s, ch, 7'h00, b, t};
    endfunction
    task send(input [23:0] w);
        integer k;
        u_host_model.xfer(w, 24, rx);
        #1;
        check("busy", w[23:20] == 4'h2 || (w[23:20] >= 4'h4 && w[23:20] <= 4'h7), ready_oe);
        for (k = 0; k < 40 && ready_oe !== 1'b0; k = k + 1)
            @(posedge clk);
        #1;
        check("ready", 1'b0, ready_oe);
    endtask
    task t_reset;
        check("wiper0", nv[7:0], wiper0);
        check("wiper1", nv[7:0], wiper1);
        check("buffers", {nv[8], nv[8]}, {buffer_enable1, buffer_enable0});
        check("standby", 1'b1, standby);
        check("sdo_oe", 1'b0, sdo_oe);
    endtask
    task t_direct;
        send(wd(`DP_CMD_WRITE_TAP, 0, 0, 1'b1, `DP_TAP_MAX));
        check("wiper0", `DP_TAP_MAX, wiper0);
        check("buffer0", nv[8], buffer_enable0);
        send(wd(`DP_CMD_TAP_UP, 0, 0, 0, 0));
        check("wiper0", `DP_TAP_MAX, wiper0);
        send(wd(`DP_CMD_WRITE_TAP, 0, 1, 0, `DP_TAP_MIN));
        send(wd(`DP_CMD_TAP_DOWN, 0, 1, 0, 0));
        check("wiper1", `DP_TAP_MIN, wiper1);
        send(wd(`DP_CMD_TAP_UP, 0, 1, 0, 0));
        check("wiper1", `DP_TAP_STEP, wiper1);
        send(wd(`DP_CMD_WRITE_TAP, 0, 2, 0, 8'h55));
        check("wipers", {`DP_TAP_STEP, `DP_TAP_MAX}, {wiper1, wiper0});
        // after a word ending in 1, this read cut one bit short would decode as a step down on channel 0
        u_host_model.xfer(wd(`DP_CMD_READ_TAP, 0, 0, 0, 8'h33), 23, rx);
        #1;
        check("wiper0", `DP_TAP_MAX, wiper0);
        check("busy", 1'b0, ready_oe);
    endtask
    task t_slots;
        for (i = 0; i < 8; i = i + 1)
            send(wd(`DP_CMD_PROG_SLOT, i[1:0], {1'b0, i[2]}, 1'b1, 8'h10 + i[7:0]));
        for (i = 0; i < 8; i = i + 1) begin
            send(wd(`DP_CMD_LOAD_TAP, i[1:0], {1'b0, i[2]}, 0, 0));
            check("wiper", 8'h10 + i[7:0], i[2] ? wiper1 : wiper0);
            check("buffer", 1'b1, i[2] ? buffer_enable1 : buffer_enable0);
            send(wd(`DP_CMD_READ_SLOT, i[1:0], {1'b0, i[2]}, 0, 0));
            send(24'h000000);
            check("slot read", wd(`DP_CMD_READ_SLOT, i[1:0], {1'b0, i[2]}, 1'b1, 8'h10 + i[7:0]), rx);
        end
    endtask
    task t_save;
        send(wd(`DP_CMD_WRITE_TAP, 0, 1, 0, 8'h5a));
        send(wd(`DP_CMD_SAVE_TAP, 2, 1, 0, 0));
        send(wd(`DP_CMD_LOAD_TAP, `DP_SLOT0, 1, 0, 0));
        check("wiper1", 8'h14, wiper1);
        send(wd(`DP_CMD_LOAD_TAP, 2, 1, 0, 0));
        check("saved", {1'b1, 8'h5a}, {buffer_enable1, wiper1});
    endtask
    task t_protect;
        @(posedge clk) wp_n_pin <= 1'b0;
        send(wd(`DP_CMD_PROG_SLOT, 3, 0, 0, 8'h77));
        send(wd(`DP_CMD_WRITE_TAP, 0, 0, 0, 8'h22));
        send(wd(`DP_CMD_SAVE_TAP, 3, 0, 0, 0));
        send(wd(`DP_CMD_LOAD_TAP, 3, 0, 0, 0));
        check("wiper0", 8'h13, wiper0);
        @(posedge clk) wp_n_pin <= 1'b1;
    endtask
    task t_chain;
        send(24'h0abcde);
        send(24'h012345);
        check("chain", 24'h0abcde, rx);
        send(wd(`DP_CMD_READ_TAP, 0, 0, 0, 0));
        send(24'h000000);
        check("tap read", wd(`DP_CMD_READ_TAP, 0, 0, 1'b1, 8'h13), rx);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 40 && ready_oe !== 1'b0; i = i + 1)
            @(posedge clk);
        #1;
        t_reset;
        t_direct;
        t_slots;
        t_save;
        t_protect;
        t_chain;
        give_verdict;
    end
endmodule // testbench
bind dual_digipot_serial_control digipot_assertions u_digipot_assertions (.clk(clk), .arst_n(arst_n),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .wp_n_pin(wp_n_pin),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ready_out(ready_out), .ready_oe(ready_oe),
    .wiper0(wiper0), .wiper1(wiper1), .buffer_enable0(buffer_enable0),
    .buffer_enable1(buffer_enable1), .standby(standby), .active(active));

// [logic/dual_digipot_serial_control.v]
`timescale 1ns/1ps
`include "digipot_regs.vh"

module dual_digipot_serial_control (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial link pins
    input wire cs_n_pin,
    input wire sclk_pin,
    input wire sdi_pin,
    input wire wp_n_pin,
    // open-drain serial output
    output wire sdo_out,
    output wire sdo_oe,
    // open-drain ready/busy, low while busy
    output wire ready_out,
    output wire ready_oe,
    // channel outputs
    output wire [7:0] wiper0,
    output wire [7:0] wiper1,
    output wire buffer_enable0,
    output wire buffer_enable1,
    // power state
    output wire standby,
    output wire active
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [3:0] sync1_ff;
    reg [3:0] sync2_ff;
    reg sclk_prev_ff;
    reg cs_prev_ff;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 4'hf;
            sync2_ff <= 4'hf;
            sclk_prev_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            sync1_ff <= {wp_n_pin, sdi_pin, sclk_pin, cs_n_pin};
            sync2_ff <= sync1_ff;
            sclk_prev_ff <= sync2_ff[1];
            cs_prev_ff <= sync2_ff[0];
        end
    end

    wire cs_n_s = sync2_ff[0];
    wire sclk_s = sync2_ff[1];
    wire sdi_s = sync2_ff[2];
    wire wp_n_s = sync2_ff[3];
    wire cs_fall = cs_prev_ff & ~cs_n_s;
    wire cs_rise = ~cs_prev_ff & cs_n_s;
    wire sclk_rise = ~sclk_prev_ff & sclk_s & ~cs_n_s;
    wire sclk_fall = sclk_prev_ff & ~sclk_s & ~cs_n_s;

    // ****************************************
    // state machine codes
    // ****************************************
    localparam ST_RECALL = 2'b00;
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    // ****************************************
    // sized constants
    // ****************************************
    // the access time is worked out in 32-bit arithmetic; only the low bits load the busy counter
    localparam [31:0] NV_ACCESS_FULL = `DP_NV_ACCESS_CYCLES;
    localparam [`DP_BUSY_W-1:0] BUSY_LOAD = NV_ACCESS_FULL[`DP_BUSY_W-1:0];
    localparam [`DP_BUSY_W-1:0] BUSY_ONE = {{(`DP_BUSY_W-1){1'b0}}, 1'b1};

    // ****************************************
    // state
    // ****************************************
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg armed_ff;
    reg [`DP_WORD_BITS-1:0] shift_ff;
    reg [`DP_WORD_BITS-1:0] nxt_shift;
    reg [`DP_CNT_W-1:0] bit_cnt_ff;
    reg [`DP_CNT_W-1:0] nxt_bit_cnt;
    reg sdo_bit_ff;
    reg nxt_sdo_bit;
    reg [`DP_BUSY_W-1:0] busy_cnt_ff;
    reg [`DP_BUSY_W-1:0] nxt_busy_cnt;
    reg [7:0] tap_ff [0:1];
    reg buf_ff [0:1];
    reg [8:0] slot_ff [0:7];
    reg [7:0] nxt_tap [0:1];
    reg nxt_buf [0:1];
    reg [8:0] nxt_slot [0:7];

    // ****************************************
    // decoded command word
    // ****************************************
    wire [3:0] cmd = shift_ff[`DP_CMD_HI:`DP_CMD_LO];
    wire [1:0] slot_sel = shift_ff[`DP_SLOT_HI:`DP_SLOT_LO];
    wire [1:0] chan_sel = shift_ff[`DP_CHAN_HI:`DP_CHAN_LO];
    wire chan = chan_sel[0];
    wire chan_ok = (chan_sel <= `DP_CHAN_LAST);
    wire [8:0] data9 = shift_ff[`DP_BUF_BIT:`DP_TAP_LO];
    wire [2:0] slot_idx = {chan, slot_sel};
    // a partial word is dropped here; busy also rejects words
    wire word_done = cs_rise & armed_ff & (bit_cnt_ff == `DP_WORD_CNT) & (state_ff == ST_IDLE);
    wire [`DP_CMD_HI:`DP_SLOT_LO] head = shift_ff[`DP_CMD_HI:`DP_SLOT_LO];
    wire nv_slow = (cmd == `DP_CMD_READ_TAP) | (cmd == `DP_CMD_READ_SLOT) | (cmd == `DP_CMD_PROG_SLOT)
                 | (cmd == `DP_CMD_LOAD_TAP) | (cmd == `DP_CMD_SAVE_TAP);

    // ****************************************
    // next-state logic
    // ****************************************
    integer i;
    always @* begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_sdo_bit = sdo_bit_ff;
        nxt_busy_cnt = busy_cnt_ff;
        for (i = 0; i < 2; i = i + 1) begin
            nxt_tap[i] = tap_ff[i];
            nxt_buf[i] = buf_ff[i];
        end
        for (i = 0; i < 8; i = i + 1) begin
            nxt_slot[i] = slot_ff[i];
        end

        // input shift on clock rise, counter saturates past one word
        if (cs_fall) begin
            nxt_bit_cnt = {`DP_CNT_W{1'b0}};
            nxt_sdo_bit = shift_ff[`DP_WORD_BITS-1];
        end else if (sclk_rise) begin
            nxt_shift = {shift_ff[`DP_WORD_BITS-2:0], sdi_s};
            if (bit_cnt_ff != {`DP_CNT_W{1'b1}}) begin
                nxt_bit_cnt = bit_cnt_ff + {{(`DP_CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (sclk_fall) begin
            // the word shifts one place per rise, so the msb is the next outgoing bit
            nxt_sdo_bit = shift_ff[`DP_WORD_BITS-1];
        end else if (cs_rise) begin
            // park released so the next select fall shows no stale low
            nxt_sdo_bit = 1'b1;
        end

        case (state_ff)
            ST_RECALL: begin
                for (i = 0; i < 2; i = i + 1) begin
                    nxt_tap[i] = slot_ff[{i[0], `DP_SLOT0}][`DP_TAP_HI:`DP_TAP_LO];
                    nxt_buf[i] = slot_ff[{i[0], `DP_SLOT0}][`DP_BUF_BIT];
                end
                nxt_busy_cnt = BUSY_LOAD;
                nxt_state = ST_BUSY;
            end
            ST_IDLE: begin
                if (word_done && chan_ok) begin
                    case (cmd)
                        `DP_CMD_WRITE_TAP: begin
                            // buffer bit cannot be set by a direct write
                            nxt_tap[chan] = data9[`DP_TAP_HI:`DP_TAP_LO];
                        end
                        `DP_CMD_READ_TAP: begin
                            nxt_shift = {head, chan_sel, {`DP_PAD_W{1'b0}}, buf_ff[chan], tap_ff[chan]};
                        end
                        `DP_CMD_READ_SLOT: begin
                            nxt_shift = {head, chan_sel, {`DP_PAD_W{1'b0}}, slot_ff[slot_idx]};
                        end
                        `DP_CMD_PROG_SLOT: begin
                            if (wp_n_s) begin
                                nxt_slot[slot_idx] = data9;
                            end
                        end
                        `DP_CMD_LOAD_TAP: begin
                            nxt_tap[chan] = slot_ff[slot_idx][`DP_TAP_HI:`DP_TAP_LO];
                            nxt_buf[chan] = slot_ff[slot_idx][`DP_BUF_BIT];
                        end
                        `DP_CMD_SAVE_TAP: begin
                            if (wp_n_s) begin
                                nxt_slot[slot_idx] = {buf_ff[chan], tap_ff[chan]};
                            end
                        end
                        `DP_CMD_TAP_UP: begin
                            if (tap_ff[chan] != `DP_TAP_MAX) begin
                                nxt_tap[chan] = tap_ff[chan] + `DP_TAP_STEP;
                            end
                        end
                        `DP_CMD_TAP_DOWN: begin
                            if (tap_ff[chan] != `DP_TAP_MIN) begin
                                nxt_tap[chan] = tap_ff[chan] - `DP_TAP_STEP;
                            end
                        end
                        default: begin
                            nxt_tap[chan] = tap_ff[chan];
                        end
                    endcase
                    if (nv_slow) begin
                        nxt_busy_cnt = BUSY_LOAD;
                        nxt_state = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                if (busy_cnt_ff <= BUSY_ONE) begin
                    nxt_busy_cnt = {`DP_BUSY_W{1'b0}};
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_busy_cnt = busy_cnt_ff - BUSY_ONE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_RECALL;
            armed_ff <= 1'b0;
            shift_ff <= {`DP_WORD_BITS{1'b0}};
            bit_cnt_ff <= {`DP_CNT_W{1'b0}};
            sdo_bit_ff <= 1'b1;
            busy_cnt_ff <= {`DP_BUSY_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            if (cs_fall) begin
                armed_ff <= 1'b1;
            end
            shift_ff <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
            sdo_bit_ff <= nxt_sdo_bit;
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // ****************************************
    // per-channel wiper and slots
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    // volatile wiper starts at the bottom, so a missing recall shows
                    tap_ff[g] <= `DP_TAP_MIN;
                    buf_ff[g] <= 1'b0;
                end else begin
                    tap_ff[g] <= nxt_tap[g];
                    buf_ff[g] <= nxt_buf[g];
                end
            end
        end
        for (g = 0; g < 8; g = g + 1) begin : g_slot
            // reset stands for power-up of an unprogrammed part
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    slot_ff[g] <= `DP_NV_RESET;
                end else begin
                    slot_ff[g] <= nxt_slot[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // outputs
    // ****************************************
    // open drain: only a low is ever driven; sdo is released while deselected
    assign sdo_out = 1'b0;
    assign sdo_oe = ~cs_n_s & ~sdo_bit_ff;
    assign ready_out = 1'b0;
    assign ready_oe = (state_ff != ST_IDLE);
    assign wiper0 = tap_ff[0];
    assign wiper1 = tap_ff[1];
    assign buffer_enable0 = buf_ff[0];
    assign buffer_enable1 = buf_ff[1];
    assign standby = cs_n_s & (state_ff == ST_IDLE);
    assign active = ~cs_n_s;

endmodule // dual_digipot_serial_control

// [shared/digipot_regs.vh]
`ifndef DIGIPOT_REGS_VH
`define DIGIPOT_REGS_VH

// ****************************************
// serial word layout
// ****************************************
`define DP_WORD_BITS 24
`define DP_CNT_W 5
`define DP_WORD_CNT 5'h18
`define DP_CMD_HI 23
`define DP_CMD_LO 20
`define DP_SLOT_HI 19
`define DP_SLOT_LO 18
`define DP_CHAN_HI 17
`define DP_CHAN_LO 16
`define DP_BUF_BIT 8
`define DP_TAP_HI 7
`define DP_TAP_LO 0
`define DP_PAD_W 7

// ****************************************
// command codes
// ****************************************
`define DP_CMD_WRITE_TAP 4'h1
`define DP_CMD_READ_TAP 4'h2
`define DP_CMD_READ_SLOT 4'h4
`define DP_CMD_PROG_SLOT 4'h5
`define DP_CMD_LOAD_TAP 4'h6
`define DP_CMD_SAVE_TAP 4'h7
`define DP_CMD_TAP_UP 4'h8
`define DP_CMD_TAP_DOWN 4'h9

// ****************************************
// values and timing
// ****************************************
`define DP_NV_RESET 9'h080
`define DP_TAP_MAX 8'hff
`define DP_TAP_MIN 8'h00
`define DP_TAP_STEP 8'h01
`define DP_CHAN_LAST 2'h1
`define DP_SLOT0 2'h0
`define DP_CLK_PERIOD_NS 4
`define DP_NV_ACCESS_NS 64
`define DP_NV_ACCESS_CYCLES ((`DP_NV_ACCESS_NS + `DP_CLK_PERIOD_NS - 1) / `DP_CLK_PERIOD_NS)
`define DP_BUSY_W 8

`endif
